// file: include/eeprom_pkg.sv
// Shared constants, types and helpers for the SPI serial EEPROM device logic.
// Assumes a 40 MHz system clock; cs_n, sck, hold_n and wp_n are synchronised before use, si is captured on sck.
package eeprom_pkg;

  // Array geometry
  localparam int ADDR_W = 10;
  localparam int DEPTH = 1024;
  localparam int PAGE_W = 4;
  localparam int PAGE_DEPTH = 16;
  localparam int DATA_W = 8;

  // Instruction codes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;
  localparam logic [7:0] OP_STATUS_WR = 8'h01;

  // Status byte field positions
  localparam int ST_HPE_BIT = 7;
  localparam int ST_BPH_BIT = 3;
  localparam int ST_BPL_BIT = 2;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BUSY_BIT = 0;

  // Protected region bases
  localparam logic [9:0] PROT_QUARTER_BASE = 10'h300;
  localparam logic [9:0] PROT_HALF_BASE = 10'h200;

  // Reset values
  localparam logic NV_HPE_RESET = 1'b0;
  localparam logic [1:0] NV_BP_RESET = 2'h0;
  localparam logic [3:0] PINS_RESET = 4'h3;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int WRITE_TIME_NS = 5000000;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 18;

  // Pins that cross into the system clock domain
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic hold_n;
    logic wp_n;
  } pins_t;

  typedef enum logic [2:0] {
    PH_OPCODE, PH_ADDR, PH_WDATA, PH_RDATA, PH_SREAD, PH_SWRITE, PH_IGNORE
  } phase_t;

  typedef enum logic [1:0] {
    PG_IDLE, PG_FETCH, PG_STORE, PG_WAIT
  } prog_t;

  // True when the block protection setting covers the address
  function automatic logic is_protected(input logic [1:0] bp, input logic [9:0] a);
    logic r;
    r = 1'b0;
    case (bp)
      2'h0: r = 1'b0;
      2'h1: r = (a >= PROT_QUARTER_BASE);
      2'h2: r = (a >= PROT_HALF_BASE);
      default: r = 1'b1;
    endcase
    return r;
  endfunction : is_protected

endpackage : eeprom_pkg

// file: core/bit_sync.sv
// Two flip-flop level synchroniser for a group of pins.
// Assumes inputs are levels that stay put for several clk periods.
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage1_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1_q <= RST;
      q <= RST;
    end else begin
      stage1_q <= d;
      q <= stage1_q;
    end
  end

endmodule : bit_sync

// file: core/byte_mem.sv
// Simple dual-port memory, one write and one read port, registered read data.
// Assumes the caller never needs read-during-write forwarding.
`timescale 1ns/1ps
module byte_mem #(
  parameter int DW = 8,
  parameter int AW = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);

  logic [DW-1:0] mem [2**AW];

  // Storage has no reset, as a real array would not
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data from a register, one cycle after the request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (re) begin
      rdata_q <= mem[raddr];
    end
  end

endmodule : byte_mem

// file: core/spi_serial_eeprom_slave.sv
// Device-side logic of a 1024-byte SPI serial EEPROM with page write and status.
// Assumes sck from the master runs well below clk/4; pins are synchronised here.
// Operation
// [RL1] Deselect gives standby and a released output; a running write still completes.
// [RL2] Internal write starts on chip select rising only after a valid sequence.
// [RL3] Capture input on rising serial clock; change output after falling serial clock.
// [RL4] Hold low pauses at once if clock low, else at next falling clock.
// [RL5] Paused device ignores input and clock; hold low releases output anytime.
// [RL6] Resume only when hold rises with clock low, from the exact paused point.
// [RL7] Master keeps hold high when unused and stays selected while paused.
// [RL8] Bytes move most significant bit first; instructions are eight bits.
// [RL9] Read instruction plus 16-bit address streams bytes; top six bits ignored.
// [RL10] Read pointer increments per byte and wraps from 03FFh to 0000h.
// [RL11] Latch set needs chip select rising right after the eight instruction bits.
// [RL12] Latch clear instruction clears the write enable latch.
// [RL13] Write takes up to 16 bytes; low nibble wraps within the page.
// [RL14] Write commits only on select rising after a whole byte; else aborted.
// [RL15] Status readable always; array reads during a write cycle are not served.
// [RL16] Latch clears at power-up, clear, status write and array write completion.
// [RL17] Status byte: protect enable, block bits, latch and busy at fixed positions.
// [RL18] Busy bit reads one during an internal write, zero otherwise.
// [RL19] Latch bit mirrors the latch; set and clear work even when protected.
// [RL20] Status write updates the nonvolatile block protection bits.
// [RL21] Hardware protection needs pin low and enable set; blocks status writes only.
// [RL22] Protect pin falling after a write cycle began leaves that write unaffected.
// [RL23] Block bits protect none, upper quarter, upper half or the whole array.
// [RL24] Array instructions during a write cycle are ignored; programming continues.
// [RL25] Writes need the latch set and skip addresses under block protection.
`timescale 1ns/1ps
module spi_serial_eeprom_slave #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
  parameter int TIMER_W = eeprom_pkg::TIMER_W
) (
  // System clock and reset
  input wire logic clk,
  input wire logic resetn,
  // SPI link, sck is the link clock
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Side pins
  input wire logic hold_n,
  input wire logic wp_n
);

  // Refuse a timer that cannot hold the write time
  if (WRITE_CYCLES < 1 || WRITE_CYCLES > 2 ** TIMER_W) begin : g_bad_timer
    $error("write cycle count does not fit the timer width");
  end

  typedef struct packed {
    eeprom_pkg::pins_t prev;
    logic sel;
    logic paused;
    eeprom_pkg::phase_t phase;
    logic [7:0] opcode;
    logic [7:0] shift;
    logic [2:0] bit_idx;
    logic [2:0] byte_cnt;
    logic [9:0] addr;
    logic [15:0] valid;
    logic fill;
    logic drive;
    logic [2:0] out_idx;
    logic [7:0] out_byte;
    logic [7:0] st_new;
    logic write_enable_latch;
    logic busy;
    logic hpe;
    logic [1:0] bp;
    eeprom_pkg::prog_t prog;
    logic [3:0] pidx;
    logic [TIMER_W-1:0] timer;
    logic so;
    logic so_oe;
  } state_t;

  state_t s_q;
  state_t s_d;
  eeprom_pkg::pins_t pins_raw;
  eeprom_pkg::pins_t pins_s;
  logic si_cap_q;

  // Memory port controls
  logic arr_we;
  logic [9:0] arr_waddr;
  logic [7:0] arr_wdata;
  logic arr_re;
  logic [9:0] arr_raddr;
  logic [7:0] arr_rdata;
  logic buf_we;
  logic [3:0] buf_waddr;
  logic [7:0] buf_wdata;
  logic buf_re;
  logic [3:0] buf_raddr;
  logic [7:0] buf_rdata;

  // Link domain: si sampled on the true rising sck edge
  // [RL3] Rising edge capture
  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      si_cap_q <= 1'b0;
    end else begin
      si_cap_q <= si;
    end
  end

  // Pin levels into the clk domain
  assign pins_raw = '{cs_n: cs_n, sck: sck, hold_n: hold_n, wp_n: wp_n};

  bit_sync #(.W(4), .RST(eeprom_pkg::PINS_RESET)) u_pin_sync (
    .clk(clk),
    .resetn(resetn),
    .d(pins_raw),
    .q(pins_s)
  );

  byte_mem #(.DW(eeprom_pkg::DATA_W), .AW(eeprom_pkg::ADDR_W)) u_array (
    .clk(clk),
    .resetn(resetn),
    .we(arr_we),
    .waddr(arr_waddr),
    .wdata(arr_wdata),
    .re(arr_re),
    .raddr(arr_raddr),
    .rdata_q(arr_rdata)
  );

  byte_mem #(.DW(eeprom_pkg::DATA_W), .AW(eeprom_pkg::PAGE_W)) u_page_buf (
    .clk(clk),
    .resetn(resetn),
    .we(buf_we),
    .waddr(buf_waddr),
    .wdata(buf_wdata),
    .re(buf_re),
    .raddr(buf_raddr),
    .rdata_q(buf_rdata)
  );

  // Whole next-state computation
  always_comb begin
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic hold_rise;
    logic complete;
    logic hw_prot;
    logic [7:0] rx_byte;
    logic [7:0] status;
    logic [9:0] prog_addr;
    logic wel_set;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    hold_rise = 1'b0;
    complete = 1'b0;
    hw_prot = 1'b0;
    rx_byte = '0;
    status = '0;
    prog_addr = '0;
    wel_set = 1'b0;
    s_d = s_q;
    arr_we = 1'b0;
    arr_waddr = '0;
    arr_wdata = '0;
    arr_re = 1'b0;
    arr_raddr = '0;
    buf_we = 1'b0;
    buf_waddr = '0;
    buf_wdata = '0;
    buf_re = 1'b0;
    buf_raddr = '0;

    // [RL17] Status byte layout
    status[eeprom_pkg::ST_HPE_BIT] = s_q.hpe;
    status[eeprom_pkg::ST_BPH_BIT] = s_q.bp[1];
    status[eeprom_pkg::ST_BPL_BIT] = s_q.bp[0];
    status[eeprom_pkg::ST_WEL_BIT] = s_q.write_enable_latch;
    status[eeprom_pkg::ST_BUSY_BIT] = s_q.busy;

    // Edge events on synchronised pins
    cs_fall = s_q.prev.cs_n & ~pins_s.cs_n;
    cs_rise = ~s_q.prev.cs_n & pins_s.cs_n;
    hold_rise = ~s_q.prev.hold_n & pins_s.hold_n;
    // [RL5] Paused edges ignored
    sck_rise = ~s_q.prev.sck & pins_s.sck & s_q.sel & ~s_q.paused & pins_s.hold_n;
    sck_fall = s_q.prev.sck & ~pins_s.sck & s_q.sel & ~s_q.paused;
    s_d.prev = pins_s;

    // [RL4] Pause entry
    if (s_q.sel && !s_q.paused && !pins_s.hold_n && !pins_s.sck) begin
      s_d.paused = 1'b1;
    // [RL6] Resume on hold rise
    end else if (s_q.sel && s_q.paused && hold_rise && !pins_s.sck) begin
      s_d.paused = 1'b0;
    end

    // Frame start clears the serial sequence only
    if (cs_fall) begin
      s_d.sel = 1'b1;
      s_d.paused = 1'b0;
      s_d.phase = eeprom_pkg::PH_OPCODE;
      s_d.bit_idx = '0;
      s_d.byte_cnt = '0;
      s_d.fill = 1'b0;
      s_d.drive = 1'b0;
    end else if (cs_rise) begin
      // [RL1] Deselect to standby
      s_d.sel = 1'b0;
      s_d.paused = 1'b0;
      s_d.drive = 1'b0;
      s_d.phase = eeprom_pkg::PH_IGNORE;
      complete = (s_q.bit_idx == 3'h0);
      hw_prot = ~pins_s.wp_n & s_q.hpe;
      if (s_q.sel) begin
        case (s_q.opcode)
          eeprom_pkg::OP_LATCH_SET: begin
            // [RL11] Set only after exact byte
            // [RL19] Latch works when protected
            if (complete && s_q.byte_cnt == 3'h1) begin
              s_d.write_enable_latch = 1'b1;
              wel_set = 1'b1;
            end
          end
          eeprom_pkg::OP_LATCH_CLR: begin
            // [RL12] Clear the latch
            if (complete && s_q.byte_cnt == 3'h1) begin
              s_d.write_enable_latch = 1'b0;
            end
          end
          eeprom_pkg::OP_WRITE: begin
            // [RL14] Commit on whole byte
            // [RL2] Start internal write
            // [RL25] Latch gates writes
            if (s_q.phase == eeprom_pkg::PH_WDATA && complete && s_q.byte_cnt == 3'h4 &&
                s_q.write_enable_latch && !s_q.busy) begin
              s_d.busy = 1'b1;
              s_d.write_enable_latch = 1'b0;
              s_d.prog = eeprom_pkg::PG_FETCH;
              s_d.pidx = '0;
            end
          end
          eeprom_pkg::OP_STATUS_WR: begin
            // [RL21] Hardware protection check
            // [RL20] Nonvolatile bits update
            if (complete && s_q.byte_cnt == 3'h2 && s_q.write_enable_latch && !s_q.busy && !hw_prot) begin
              s_d.hpe = s_q.st_new[eeprom_pkg::ST_HPE_BIT];
              s_d.bp = {s_q.st_new[eeprom_pkg::ST_BPH_BIT], s_q.st_new[eeprom_pkg::ST_BPL_BIT]};
              // [RL16] Clear on status write
              s_d.write_enable_latch = 1'b0;
              s_d.busy = 1'b1;
              s_d.prog = eeprom_pkg::PG_WAIT;
              s_d.timer = '0;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (sck_rise) begin
      // [RL8] Most significant bit first
      rx_byte = {s_q.shift[6:0], si_cap_q};
      s_d.shift = rx_byte;
      s_d.bit_idx = s_q.bit_idx + 3'h1;
      if (s_q.bit_idx == 3'h7) begin
        if (s_q.byte_cnt != 3'h4) begin
          s_d.byte_cnt = s_q.byte_cnt + 3'h1;
        end
        case (s_q.phase)
          eeprom_pkg::PH_OPCODE: begin
            s_d.opcode = rx_byte;
            if (rx_byte == eeprom_pkg::OP_READ || rx_byte == eeprom_pkg::OP_WRITE) begin
              // [RL24] Array access ignored while busy
              s_d.phase = s_q.busy ? eeprom_pkg::PH_IGNORE : eeprom_pkg::PH_ADDR;
              s_d.valid = '0;
            end else if (rx_byte == eeprom_pkg::OP_STATUS_RD) begin
              // [RL15] Status readable while busy
              s_d.phase = eeprom_pkg::PH_SREAD;
              s_d.out_byte = status;
              s_d.out_idx = 3'h7;
            end else if (rx_byte == eeprom_pkg::OP_STATUS_WR) begin
              s_d.phase = eeprom_pkg::PH_SWRITE;
            end else begin
              s_d.phase = eeprom_pkg::PH_IGNORE;
            end
          end
          eeprom_pkg::PH_ADDR: begin
            if (s_q.byte_cnt == 3'h1) begin
              // [RL9] Upper six bits dropped
              s_d.addr[9:8] = rx_byte[1:0];
            end else begin
              s_d.addr[7:0] = rx_byte;
              if (s_q.opcode == eeprom_pkg::OP_READ) begin
                // [RL9] First byte fetched at once
                arr_re = 1'b1;
                arr_raddr = {s_q.addr[9:8], rx_byte};
                s_d.fill = 1'b1;
                s_d.phase = eeprom_pkg::PH_RDATA;
              end else begin
                s_d.phase = eeprom_pkg::PH_WDATA;
              end
            end
          end
          eeprom_pkg::PH_WDATA: begin
            // [RL13] Page buffer with nibble wrap
            buf_we = 1'b1;
            buf_waddr = s_q.addr[3:0];
            buf_wdata = rx_byte;
            s_d.valid[s_q.addr[3:0]] = 1'b1;
            s_d.addr[3:0] = s_q.addr[3:0] + 4'h1;
          end
          eeprom_pkg::PH_SWRITE: begin
            if (s_q.byte_cnt == 3'h1) begin
              s_d.st_new = rx_byte;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (sck_fall) begin
      // [RL3] Output moves on falling edge
      if (s_q.phase == eeprom_pkg::PH_RDATA || s_q.phase == eeprom_pkg::PH_SREAD) begin
        s_d.so = s_q.out_byte[s_q.out_idx];
        s_d.drive = 1'b1;
        s_d.out_idx = s_q.out_idx - 3'h1;
        if (s_q.out_idx == 3'h0) begin
          if (s_q.phase == eeprom_pkg::PH_RDATA) begin
            arr_re = 1'b1;
            arr_raddr = s_q.addr;
            s_d.fill = 1'b1;
          end else begin
            s_d.out_byte = status;
          end
        end
      end
    end

    // Read data lands two clk cycles after the request, before the next falling edge needs it
    if (s_q.fill) begin
      s_d.fill = 1'b0;
      s_d.out_byte = arr_rdata;
      s_d.out_idx = 3'h7;
      // [RL10] Pointer wraps at top
      s_d.addr = s_q.addr + 10'h1;
    end

    // Programming runs regardless of chip select
    prog_addr = {s_q.addr[9:4], s_q.pidx};
    case (s_q.prog)
      eeprom_pkg::PG_FETCH: begin
        buf_re = 1'b1;
        buf_raddr = s_q.pidx;
        s_d.prog = eeprom_pkg::PG_STORE;
      end
      eeprom_pkg::PG_STORE: begin
        // [RL23] Protected bytes skipped
        if (s_q.valid[s_q.pidx] && !eeprom_pkg::is_protected(s_q.bp, prog_addr)) begin
          arr_we = 1'b1;
          arr_waddr = prog_addr;
          arr_wdata = buf_rdata;
        end
        s_d.pidx = s_q.pidx + 4'h1;
        s_d.timer = '0;
        s_d.prog = (s_q.pidx == 4'hf) ? eeprom_pkg::PG_WAIT : eeprom_pkg::PG_FETCH;
      end
      eeprom_pkg::PG_WAIT: begin
        // [RL22] Pin no longer consulted
        s_d.timer = s_q.timer + TIMER_W'(1);
        if (s_q.timer == TIMER_W'(WRITE_CYCLES - 1)) begin
          // [RL18] Busy drops at the end
          s_d.busy = 1'b0;
          // [RL16] Clear on completion; a set in this same cycle wins
          s_d.write_enable_latch = wel_set;
          s_d.prog = eeprom_pkg::PG_IDLE;
        end
      end
      default: begin
      end
    endcase

    // [RL5] Hold low releases the output
    // A hold rise with the clock high leaves the device paused, so stay released
    s_d.so_oe = s_d.sel & s_d.drive & ~s_d.paused & pins_s.hold_n;
  end

  // State register; power-up values stand in for the missing reset pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{prev: eeprom_pkg::PINS_RESET, phase: eeprom_pkg::PH_IGNORE,
               prog: eeprom_pkg::PG_IDLE, hpe: eeprom_pkg::NV_HPE_RESET,
               bp: eeprom_pkg::NV_BP_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign so = s_q.so;
  assign so_oe = s_q.so_oe;

endmodule : spi_serial_eeprom_slave

// file: verif/eeprom_chk.sv
// Port-level checks for the SPI EEPROM device logic.
// Assumes a mode 0 master on the link and the 2-3 clk pin synchronisers.
`timescale 1ns/1ps
module eeprom_chk #(
  parameter int WRITE_CYCLES = 20,
  parameter int TIMER_W = 18
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  // Side pins
  input wire logic hold_n,
  input wire logic wp_n
);
  logic [3:0] live_q;
  logic [3:0] high_q;
  // Samples selected and not held, and samples of sck high; saturate to stay small
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      live_q <= 4'h0;
      high_q <= 4'h0;
    end else begin
      live_q <= (cs_n || !hold_n) ? 4'h0 : live_q + {3'h0, live_q != 4'hf};
      high_q <= !sck ? 4'h0 : high_q + {3'h0, high_q != 4'hf};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_desel_off; cs_n [*4] |-> !so_oe; endproperty
  a_desel_off: assert property (p_desel_off)
    else $error("output enabled while deselected");
  property p_hold_off; !hold_n [*4] |-> !so_oe; endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("output enabled while paused");
  property p_hold_fast; (!hold_n && !sck && !cs_n) |-> ##[0:4] !so_oe; endproperty
  a_hold_fast: assert property (p_hold_fast)
    else $error("pause with clock low not prompt");
  property p_fall_cause; $fell(so_oe) |-> live_q < 4'h6; endproperty
  a_fall_cause: assert property (p_fall_cause)
    else $error("output released without deselect or pause");
  property p_rise_cause; $rose(so_oe) |-> live_q >= 4'h2; endproperty
  a_rise_cause: assert property (p_rise_cause)
    else $error("output enabled without selection");
  property p_oe_hold; $rose(so_oe) |-> hold_n && $past(hold_n, 2); endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("output resumed without hold high");
  property p_so_steady; ($changed(so) && so_oe && $past(so_oe)) |-> high_q <= 4'h2; endproperty
  a_so_steady: assert property (p_so_steady)
    else $error("data out changed late in clock high phase");
  property p_oe_after_fall; $rose(so_oe) |-> high_q <= 4'h2; endproperty
  a_oe_after_fall: assert property (p_oe_after_fall)
    else $error("output enabled away from a clock fall");
endmodule : eeprom_chk

bind spi_serial_eeprom_slave eeprom_chk #(
  .WRITE_CYCLES(WRITE_CYCLES),
  .TIMER_W(TIMER_W)
) u_eeprom_chk (
  .clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si),
  .so(so), .so_oe(so_oe), .hold_n(hold_n), .wp_n(wp_n)
);

// file: verif/spi_master_model.sv
// Behavioural SPI master on the far side of the EEPROM link.
// Assumes mode 0; the 160 ns link clock stands low between frames.
`timescale 1ns/1ps
module spi_master_model (
  // Link towards the device
  output logic sck,
  output logic cs_n,
  output logic si,
  // Side pins
  output logic hold_n,
  output logic wp_n,
  // Device answer
  input wire logic so,
  input wire logic so_oe
);
  logic line_q;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
    line_q = 1'b0;
  end
  task start;
    cs_n = 1'b0;
    #120;
  endtask : start
  task stop;
    #120;
    cs_n = 1'b1;
    si = ~si;
    #300;
  endtask : stop
  task shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      si = tx[7 - i];
      #80;
      sck = 1'b1;
      // Read late in the high phase: the device answers up to 100 ns after a fall
      #79;
      line_q = so_oe ? so : ~line_q;
      rx = {rx[6:0], line_q};
      #1;
      sck = 1'b0;
    end
  endtask : shift
  task pause;
    hold_n = 1'b0;
    repeat (2) begin
      #80;
      sck = 1'b1;
      si = ~si;
      #80;
      sck = 1'b0;
    end
    #80;
    sck = 1'b1;
    #40;
    hold_n = 1'b1;
    #40;
    sck = 1'b0;
    #80;
    hold_n = 1'b0;
    #80;
    hold_n = 1'b1;
    #80;
  endtask : pause
endmodule : spi_master_model

// file: verif/tb_top.sv
// Self-checking bench for the SPI EEPROM device logic.
// Assumes the master model drives the link; the bench owns clk and resetn.
`timescale 1ns/1ps
module tb_top;
  localparam int WCYC = 600;
  localparam logic [15:0] ROWS [5] = '{16'h0602, 16'h0400, 16'h0602, 16'hff02, 16'h0400};
  logic clk;
  logic resetn;
  logic sck, cs_n, si, so, so_oe, hold_n, wp_n;
  logic oe_seen;
  logic [7:0] rd, r1, r2;
  logic [7:0] got [4];
  int mismatches;
  int tests_run;
  int cycles;

  spi_serial_eeprom_slave #(.WRITE_CYCLES(WCYC), .TIMER_W(18)) u_spi_serial_eeprom_slave (
    .clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si),
    .so(so), .so_oe(so_oe), .hold_n(hold_n), .wp_n(wp_n)
  );
  spi_master_model u_spi_master_model (
    .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe)
  );

  // Clock, reset and a hang limit well above the expected run
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    oe_seen = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
  end
  always @(posedge clk) begin
    cycles++;
    if (so_oe === 1'b1) oe_seen = 1'b1;
    if (cycles == 60000) begin
      mismatches++;
      close_out();
    end
  end

  task check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check8
  task cmd1(input logic [7:0] op);
    u_spi_master_model.start();
    u_spi_master_model.shift(op, 8, rd);
    u_spi_master_model.stop();
  endtask : cmd1
  task cmd2(input logic [7:0] op, input logic [7:0] b, output logic [7:0] r);
    u_spi_master_model.start();
    u_spi_master_model.shift(op, 8, rd);
    u_spi_master_model.shift(b, 8, r);
    u_spi_master_model.stop();
  endtask : cmd2
  task hdr(input logic [7:0] op, input logic [15:0] a);
    u_spi_master_model.start();
    u_spi_master_model.shift(op, 8, rd);
    u_spi_master_model.shift(a[15:8], 8, rd);
    u_spi_master_model.shift(a[7:0], 8, rd);
  endtask : hdr
  task wr(input logic [15:0] a, input logic [7:0] d0, d1, d2, input int n);
    hdr(eeprom_pkg::OP_WRITE, a);
    u_spi_master_model.shift(d0, 8, rd);
    if (n > 1) u_spi_master_model.shift(d1, 8, rd);
    if (n > 2) u_spi_master_model.shift(d2, 8, rd);
    u_spi_master_model.stop();
  endtask : wr
  task rd_arr(input logic [15:0] a, input int n);
    hdr(eeprom_pkg::OP_READ, a);
    for (int i = 0; i < n; i++) u_spi_master_model.shift(8'h00, 8, got[i]);
    u_spi_master_model.stop();
  endtask : rd_arr
  task stat(input logic [7:0] exp, input string what);
    cmd2(eeprom_pkg::OP_STATUS_RD, 8'h00, r1);
    check8(what, exp, r1);
  endtask : stat
  task wait_idle;
    int n;
    n = 0;
    cmd2(eeprom_pkg::OP_STATUS_RD, 8'h00, r1);
    while (r1[0] !== 1'b0 && n < 20) begin
      cmd2(eeprom_pkg::OP_STATUS_RD, 8'h00, r1);
      n++;
    end
    check8("busy cleared", 8'h00, {7'h00, r1[0]});
  endtask : wait_idle
  task close_out;
    $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // Main sequence: latch table, then array, hold, protection and reset cases
  initial begin
    wait (resetn === 1'b1);
    repeat (4) @(posedge clk);
    stat(8'h00, "status after reset");
    for (int i = 0; i < 5; i++) begin
      cmd1(ROWS[i][15:8]);
      stat(ROWS[i][7:0], "status after command");
    end
    u_spi_master_model.start();
    u_spi_master_model.shift(eeprom_pkg::OP_LATCH_SET, 8, rd);
    u_spi_master_model.shift(8'h00, 1, rd);
    u_spi_master_model.stop();
    stat(8'h00, "latch with extra clock");
    wr(16'h0000, 8'hff, 8'h00, 8'h00, 1);
    stat(8'h00, "write without latch");
    cmd1(eeprom_pkg::OP_LATCH_SET);
    wr(16'hfffe, 8'ha5, 8'h3c, 8'h96, 3);
    stat(8'h01, "status during write");
    oe_seen = 1'b0;
    rd_arr(16'h0000, 1);
    check8("array read while busy", 8'h00, {7'h00, oe_seen});
    wait_idle();
    stat(8'h00, "latch after write");
    cmd1(eeprom_pkg::OP_LATCH_SET);
    hdr(eeprom_pkg::OP_WRITE, 16'h0000);
    u_spi_master_model.shift(8'h11, 8, rd);
    u_spi_master_model.shift(8'h22, 4, rd);
    u_spi_master_model.stop();
    stat(8'h02, "aborted write");
    wr(16'h0000, 8'h5a, 8'h00, 8'h00, 1);
    wait_idle();
    rd_arr(16'h03fe, 3);
    check8("read 3fe", 8'ha5, got[0]);
    check8("read 3ff", 8'h3c, got[1]);
    check8("read wrapped 000", 8'h5a, got[2]);
    rd_arr(16'h03f0, 1);
    check8("page wrap byte", 8'h96, got[0]);
    hdr(eeprom_pkg::OP_READ, 16'h03fe);
    u_spi_master_model.shift(8'h00, 3, r1);
    u_spi_master_model.pause();
    u_spi_master_model.shift(8'h00, 5, r2);
    u_spi_master_model.stop();
    check8("read across pause", 8'ha5, {r1[2:0], r2[4:0]});
    cmd1(eeprom_pkg::OP_LATCH_SET);
    cmd2(eeprom_pkg::OP_STATUS_WR, 8'h04, rd);
    wait_idle();
    stat(8'h04, "quarter protect");
    cmd1(eeprom_pkg::OP_LATCH_SET);
    wr(16'h03ff, 8'h00, 8'h00, 8'h00, 1);
    wait_idle();
    rd_arr(16'h03ff, 1);
    check8("protected byte kept", 8'h3c, got[0]);
    cmd1(eeprom_pkg::OP_LATCH_SET);
    cmd2(eeprom_pkg::OP_STATUS_WR, 8'h84, rd);
    @(posedge clk);
    u_spi_master_model.wp_n <= 1'b0;
    wait_idle();
    stat(8'h84, "pin fall during write");
    cmd1(eeprom_pkg::OP_LATCH_SET);
    cmd2(eeprom_pkg::OP_STATUS_WR, 8'h00, rd);
    stat(8'h86, "hardware protected status");
    @(posedge clk);
    u_spi_master_model.wp_n <= 1'b1;
    cmd2(eeprom_pkg::OP_STATUS_WR, 8'h00, rd);
    wait_idle();
    stat(8'h00, "unprotected status write");
    cmd1(eeprom_pkg::OP_LATCH_SET);
    hdr(eeprom_pkg::OP_STATUS_RD, 16'h0000);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    u_spi_master_model.stop();
    stat(8'h00, "status after mid-run reset");
    close_out();
  end
endmodule : tb_top
